//--- pkg/cpc_pkg.sv
// constants and types shared by the charge pump control block
package cpc_pkg;

  // register indices; the byte address is four times the index
  localparam logic [11:0] CPC_CTRL_IDX = 12'h20D;
  localparam logic [11:0] CPC_IRQ_STAT_IDX = 12'h20E;
  localparam logic [11:0] CPC_IRQ_MASK_IDX = 12'h20F;
  localparam logic [11:0] CPC_CTRL_ADDR = {CPC_CTRL_IDX[9:0], 2'h0};
  localparam logic [11:0] CPC_IRQ_STAT_ADDR = {CPC_IRQ_STAT_IDX[9:0], 2'h0};
  localparam logic [11:0] CPC_IRQ_MASK_ADDR = {CPC_IRQ_MASK_IDX[9:0], 2'h0};

  // control register field positions
  localparam int CPC_MODE_HI = 7;
  localparam int CPC_MODE_LO = 6;
  localparam int CPC_CLKSEL_BIT = 5;
  localparam int CPC_REQ_BIT = 2;
  localparam int CPC_THR_BIT = 1;
  localparam int CPC_RDY_BIT = 0;
  localparam logic [7:0] CPC_CTRL_RESET = 8'h00;

  // enable-mode encodings
  localparam logic [1:0] CPC_MODE_OFF = 2'h0;
  localparam logic [1:0] CPC_MODE_PERIPH = 2'h1;
  localparam logic [1:0] CPC_MODE_AUTO = 2'h2;
  localparam logic [1:0] CPC_MODE_ON = 2'h3;

  // interrupt event bits, same layout in status and mask
  localparam int CPC_EV_NUM = 3;
  localparam int CPC_EV_SETTLED = 0;
  localparam int CPC_EV_SUPPLY_LOW = 1;
  localparam int CPC_EV_REQUEST = 2;
  localparam logic [CPC_EV_NUM-1:0] CPC_IRQ_RESET = 3'h0;

  // pump clock source codes driven to the analog core
  localparam logic [1:0] CPC_CLK_NONE = 2'h0;
  localparam logic [1:0] CPC_CLK_INTERNAL = 2'h1;
  localparam logic [1:0] CPC_CLK_CONV_RC = 2'h2;
  localparam logic [1:0] CPC_CLK_SYS_DIV = 2'h3;

  // pump sequencing states
  typedef enum logic [1:0] {
    CPC_PUMP_OFF,
    CPC_PUMP_SETTLING,
    CPC_PUMP_READY
  } cpc_pump_t;

endpackage

//--- test/cpc_pump_model.sv
// behavioural analog pump that settles some cycles after starting
`timescale 1ns/1ps
module cpc_pump_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pump_enable,
  input wire logic [1:0] pump_clock_source,
  input wire logic [7:0] settle_cycles,
  output logic pump_steady_in
);
  logic [7:0] cnt_q;
  // no clock means no pumping, so steady drops at once when stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      pump_steady_in <= 1'h0;
    end else if (!pump_enable || pump_clock_source == 2'h0) begin
      cnt_q <= 8'h00;
      pump_steady_in <= 1'h0;
    end else if (cnt_q >= settle_cycles) begin
      pump_steady_in <= 1'h1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

//--- test/cpc_top_bench.sv
// self-checking apb bench for the charge pump control block
`timescale 1ns/1ps
module cpc_top_bench;
  localparam logic [11:0] CA = cpc_pkg::CPC_CTRL_ADDR;
  localparam logic [11:0] SA = cpc_pkg::CPC_IRQ_STAT_ADDR;
  localparam logic [11:0] MA = cpc_pkg::CPC_IRQ_MASK_ADDR;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic supply_above_in, converter_active, pump_request_in;
  logic conversion_running, pump_steady_in, pump_enable;
  logic [1:0] pump_clock_source;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  int error_cnt, cmp_count;
  cpc_top i_cpc_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pstrb, .pready, .prdata, .pslverr, .supply_above_in,
    .converter_active, .pump_request_in, .conversion_running,
    .pump_steady_in, .pump_enable, .pump_clock_source, .irq);
  cpc_pump_model i_cpc_pump_model (.pclk, .presetn, .pump_enable,
    .pump_clock_source, .settle_cycles(8'h05), .pump_steady_in);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one full transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    // waits for the answer; only the watchdog ends a stuck transfer
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1);
    chk(32'(n), 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask
  // bounded wait, at most 12 cycles, for pump_enable to reach the expected level
  task automatic wen(input logic e);
    int n;
    n = 0;
    while (pump_enable !== e && n < 12) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, pump_enable}, {31'h0, e});
  endtask
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  // a stuck handshake ends the run here; the enable waits are bounded
  initial begin
    repeat (3000) @(posedge pclk);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {converter_active, pump_request_in, conversion_running} = '0;
    supply_above_in = 1'h1;
    pstrb = 4'hF;
    error_cnt = 0;
    cmp_count = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rdc(CA, 32'h2);
    apb(1'h1, 12'h000, 32'hFF);
    rdc(12'h000, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr_on: begin
      apb(1'h1, CA, 32'hFF);
      wen(1'h1);
      repeat (10) @(posedge pclk);
      rdc(CA, 32'hE3);
      chk({30'h0, pump_clock_source}, 32'h1);
    end
    pump_request_in <= 1'h1;
    repeat (3) @(posedge pclk);
    rdc(CA, 32'hE7);
    rdc(SA, 32'h5);
    apb(1'h1, MA, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, MA, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'h1, SA, 32'h5);
    rdc(SA, 32'h0);
    apb(1'h1, CA, 32'h80);
    wen(1'h0);
    rdc(CA, 32'h86);
    supply_above_in <= 1'h0;
    wen(1'h1);
    repeat (3) @(posedge pclk);
    chk({30'h0, pump_clock_source}, 32'h2);
    conversion_running <= 1'h1;
    repeat (4) @(posedge pclk);
    chk({30'h0, pump_clock_source}, 32'h3);
    apb(1'h0, SA, 32'h0);
    chk(rd & 32'h2, 32'h2);
    apb(1'h1, CA, 32'h40);
    wen(1'h0);
    converter_active <= 1'h1;
    wen(1'h1);
    supply_above_in <= 1'h1;
    wen(1'h0);
    supply_above_in <= 1'h0;
    wen(1'h1);
    converter_active <= 1'h0;
    wen(1'h0);
    apb(1'h1, CA, 32'hC0);
    wen(1'h1);
    rdc(CA, 32'hC4);
    repeat (10) @(posedge pclk);
    rdc(CA, 32'hC5);
    apb(1'h1, CA, 32'h00);
    wen(1'h0);
    final_report();
  end
endmodule
bind cpc_top cpc_top_properties i_cpc_top_properties (.pclk, .presetn,
  .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .pslverr,
  .supply_above_in, .converter_active, .conversion_running, .pump_enable,
  .pump_clock_source);

//--- test/cpc_top_properties.sv
// concurrent checks on the charge pump control ports
`timescale 1ns/1ps
module cpc_top_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pslverr,
  input wire logic supply_above_in,
  input wire logic converter_active,
  input wire logic conversion_running,
  input wire logic pump_enable,
  input wire logic [1:0] pump_clock_source
);
  logic [1:0] mode_q;
  logic sel_q;
  logic wr_ctrl;
  logic unmapped;
  // shadow of mode and clock select, which are not visible at the ports
  assign wr_ctrl = psel & penable & pwrite & pstrb[0]
                 & (paddr == cpc_pkg::CPC_CTRL_ADDR);
  assign unmapped = (paddr != cpc_pkg::CPC_CTRL_ADDR)
                  & (paddr != cpc_pkg::CPC_IRQ_STAT_ADDR)
                  & (paddr != cpc_pkg::CPC_IRQ_MASK_ADDR);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 2'h0;
      sel_q <= 1'h0;
    end else if (wr_ctrl) begin
      mode_q <= pwdata[7:6];
      sel_q <= pwdata[5];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // enable lags the mode by one edge and the inputs by two
  property p_on;
    $past(mode_q) == 2'h3 |-> pump_enable;
  endproperty
  a_on: assert property (p_on) else $error("pump off in mode on");
  property p_auto;
    $past(mode_q) == 2'h2 |-> pump_enable == !$past(supply_above_in, 2);
  endproperty
  a_auto: assert property (p_auto) else $error("auto mode wrong");
  property p_periph;
    $past(mode_q) == 2'h1 |-> pump_enable ==
      ($past(converter_active, 2) && !$past(supply_above_in, 2));
  endproperty
  a_periph: assert property (p_periph) else $error("gated mode wrong");
  property p_off;
    $past(mode_q) == 2'h0 |-> !pump_enable;
  endproperty
  a_off: assert property (p_off) else $error("pump on in mode off");
  property p_src_off;
    !$past(pump_enable) |-> pump_clock_source == cpc_pkg::CPC_CLK_NONE;
  endproperty
  a_src_off: assert property (p_src_off) else $error("clock while off");
  property p_src_int;
    $past(pump_enable) && $past(sel_q) |->
      pump_clock_source == cpc_pkg::CPC_CLK_INTERNAL;
  endproperty
  a_src_int: assert property (p_src_int) else $error("not internal");
  property p_src_conv;
    $past(pump_enable) && !$past(sel_q) &&
      $past(conversion_running) == $past(conversion_running, 2) |->
      pump_clock_source == ($past(conversion_running) ?
        cpc_pkg::CPC_CLK_SYS_DIV : cpc_pkg::CPC_CLK_CONV_RC);
  endproperty
  a_src_conv: assert property (p_src_conv) else $error("bad source");
  property p_slverr;
    psel && penable |-> pslverr == unmapped;
  endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr wrong");
endmodule

//--- verilog/cpc_clk_sel.sv
// pump clock source selection
`timescale 1ns/1ps
module cpc_clk_sel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pump_on,
  input wire logic pump_clock_select,
  input wire logic conversion_running,
  output logic [1:0] pump_clock_source
);

  typedef struct packed {
    logic [1:0] src;
  } cpc_clk_t;

  cpc_clk_t s_q;
  cpc_clk_t s_d;

  // no source while the pump is off saves oscillator current
  always_comb begin
    s_d = s_q;
    if (!pump_on) begin
      s_d.src = cpc_pkg::CPC_CLK_NONE;
    end else if (pump_clock_select) begin
      s_d.src = cpc_pkg::CPC_CLK_INTERNAL;
    end else if (conversion_running) begin
      s_d.src = cpc_pkg::CPC_CLK_SYS_DIV;
    end else begin
      s_d.src = cpc_pkg::CPC_CLK_CONV_RC;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pump_clock_source = s_q.src;

endmodule

//--- verilog/cpc_irq.sv
// sticky event status with mask and one level interrupt
`timescale 1ns/1ps
module cpc_irq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [cpc_pkg::CPC_EV_NUM-1:0] event_set,
  input wire logic stat_wr,
  input wire logic mask_wr,
  input wire logic [cpc_pkg::CPC_EV_NUM-1:0] wr_data,
  output logic [cpc_pkg::CPC_EV_NUM-1:0] irq_status,
  output logic [cpc_pkg::CPC_EV_NUM-1:0] irq_mask,
  output logic irq
);

  typedef struct packed {
    logic [cpc_pkg::CPC_EV_NUM-1:0] stat;
    logic [cpc_pkg::CPC_EV_NUM-1:0] mask;
  } cpc_irq_t;

  cpc_irq_t s_q;
  cpc_irq_t s_d;

  // per bit: write one clears, a new event in the same cycle wins
  always_comb begin
    s_d = s_q;
    for (int i = 0; i < cpc_pkg::CPC_EV_NUM; i++) begin
      if (stat_wr && wr_data[i]) begin
        s_d.stat[i] = 1'b0;
      end
      if (event_set[i]) begin
        s_d.stat[i] = 1'b1;
      end
    end
    if (mask_wr) begin
      s_d.mask = wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign irq_status = s_q.stat;
  assign irq_mask = s_q.mask;
  // level output, follows registered status and mask
  assign irq = |(s_q.stat & s_q.mask);

endmodule

//--- verilog/cpc_top.sv
// charge pump control: enable modes, status flags and apb registers
`timescale 1ns/1ps

module cpc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic supply_above_in,
  input wire logic converter_active,
  input wire logic pump_request_in,
  input wire logic conversion_running,
  input wire logic pump_steady_in,
  output logic pump_enable,
  output logic [1:0] pump_clock_source,
  output logic irq
);

  typedef struct packed {
    logic [1:0] mode;
    logic clk_sel;
    logic thr;
    logic req;
    logic periph;
    cpc_pkg::cpc_pump_t pump;
    logic en;
    logic [31:0] rdata;
    logic err;
  } cpc_top_t;

  cpc_top_t s_q;
  cpc_top_t s_d;

  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic addr_ctrl;
  logic addr_stat;
  logic addr_mask;
  logic addr_hit;
  logic demand;
  logic [7:0] ctrl_rd;
  logic [cpc_pkg::CPC_EV_NUM-1:0] ev;
  logic [cpc_pkg::CPC_EV_NUM-1:0] irq_status;
  logic [cpc_pkg::CPC_EV_NUM-1:0] irq_mask;
  logic stat_wr;
  logic mask_wr;

  // apb phase decode
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;

  // address decode, only the three aligned words respond
  assign addr_ctrl = (paddr == cpc_pkg::CPC_CTRL_ADDR);
  assign addr_stat = (paddr == cpc_pkg::CPC_IRQ_STAT_ADDR);
  assign addr_mask = (paddr == cpc_pkg::CPC_IRQ_MASK_ADDR);
  assign addr_hit = addr_ctrl || addr_stat || addr_mask;

  // write commits only at the completing access edge; lane 0 carries
  // every implemented bit, other lanes are ignored
  assign wr_en = access_ph && pwrite && addr_hit && pstrb[0];
  assign stat_wr = wr_en && addr_stat;
  assign mask_wr = wr_en && addr_mask;

  // control register read view; bits 4:3 read zero
  always_comb begin
    ctrl_rd = cpc_pkg::CPC_CTRL_RESET;
    ctrl_rd[cpc_pkg::CPC_MODE_HI:cpc_pkg::CPC_MODE_LO] = s_q.mode;
    ctrl_rd[cpc_pkg::CPC_CLKSEL_BIT] = s_q.clk_sel;
    ctrl_rd[cpc_pkg::CPC_REQ_BIT] = s_q.req;
    ctrl_rd[cpc_pkg::CPC_THR_BIT] = s_q.thr;
    ctrl_rd[cpc_pkg::CPC_RDY_BIT] =
      (s_q.pump == cpc_pkg::CPC_PUMP_READY);
  end

  // pump demand from the enable mode and registered inputs
  always_comb begin
    case (s_q.mode)
      cpc_pkg::CPC_MODE_ON: begin
        demand = 1'b1;
      end
      cpc_pkg::CPC_MODE_AUTO: begin
        demand = !s_q.thr;
      end
      cpc_pkg::CPC_MODE_PERIPH: begin
        // supply is not looked at until a peripheral is active
        demand = s_q.periph && !s_q.thr;
      end
      cpc_pkg::CPC_MODE_OFF: begin
        demand = 1'b0;
      end
      default: begin
        demand = 1'b0;
      end
    endcase
  end

  // events for the sticky status register
  always_comb begin
    ev = '0;
    ev[cpc_pkg::CPC_EV_SETTLED] =
      (s_q.pump != cpc_pkg::CPC_PUMP_READY) &&
      (s_d.pump == cpc_pkg::CPC_PUMP_READY);
    ev[cpc_pkg::CPC_EV_SUPPLY_LOW] = s_q.thr && !supply_above_in;
    ev[cpc_pkg::CPC_EV_REQUEST] = !s_q.req && pump_request_in;
  end

  // next state: registers, status sampling, pump sequence, read data
  always_comb begin
    s_d = s_q;

    // software writes to the control word; flags are read only
    if (wr_en && addr_ctrl) begin
      s_d.mode = pwdata[cpc_pkg::CPC_MODE_HI:cpc_pkg::CPC_MODE_LO];
      s_d.clk_sel = pwdata[cpc_pkg::CPC_CLKSEL_BIT];
    end

    // comparator and peripheral status sampled every cycle
    s_d.thr = supply_above_in;
    s_d.req = pump_request_in;
    s_d.periph = converter_active;

    // pump sequencing; steady state comes from the analog core
    // because no fixed settling time is known
    case (s_q.pump)
      cpc_pkg::CPC_PUMP_OFF: begin
        if (demand) begin
          s_d.pump = cpc_pkg::CPC_PUMP_SETTLING;
        end
      end
      cpc_pkg::CPC_PUMP_SETTLING: begin
        if (!demand) begin
          s_d.pump = cpc_pkg::CPC_PUMP_OFF;
        end else if (pump_steady_in) begin
          s_d.pump = cpc_pkg::CPC_PUMP_READY;
        end
      end
      cpc_pkg::CPC_PUMP_READY: begin
        if (!demand) begin
          s_d.pump = cpc_pkg::CPC_PUMP_OFF;
        end else if (!pump_steady_in) begin
          // pump sagged, ready drops until it settles again
          s_d.pump = cpc_pkg::CPC_PUMP_SETTLING;
        end
      end
      default: begin
        s_d.pump = cpc_pkg::CPC_PUMP_OFF;
      end
    endcase

    // enable follows demand with one register stage
    s_d.en = demand;

    // read data and error captured in setup so they leave flops
    if (setup_ph) begin
      s_d.err = !addr_hit;
      s_d.rdata = '0;
      if (!pwrite) begin
        if (addr_ctrl) begin
          s_d.rdata = {24'h000000, ctrl_rd};
        end else if (addr_stat) begin
          s_d.rdata = {29'h0, irq_status};
        end else if (addr_mask) begin
          s_d.rdata = {29'h0, irq_mask};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // one wait-free access phase; setup already prepared the answer
  assign pready = access_ph;
  assign pslverr = access_ph && s_q.err;
  assign prdata = s_q.rdata;
  assign pump_enable = s_q.en;

  // clock source follows the registered enable and select bit
  cpc_clk_sel i_cpc_clk_sel (
    .pclk(pclk),
    .presetn(presetn),
    .pump_on(s_q.en),
    .pump_clock_select(s_q.clk_sel),
    .conversion_running(conversion_running),
    .pump_clock_source(pump_clock_source)
  );

  // sticky events, mask and interrupt line
  cpc_irq i_cpc_irq (
    .pclk(pclk),
    .presetn(presetn),
    .event_set(ev),
    .stat_wr(stat_wr),
    .mask_wr(mask_wr),
    .wr_data(pwdata[cpc_pkg::CPC_EV_NUM-1:0]),
    .irq_status(irq_status),
    .irq_mask(irq_mask),
    .irq(irq)
  );

endmodule
